// ---- test_wdm_watchdog.sv ----
// Purpose: self-checking bench for the windowed watchdog over axi4-lite
// Assumes: shortened counts LOWER_TC 16, UPPER_BASE_TC 64, CM_TIMEOUT_CYC 200
// Notes: pin level comes from the pull-up model; oscillator halts with osc_run low
`include "wdm_watchdog_regs.vh"
`define CK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("ERROR %0t got %0h expected %0h", $time, (g), (e)); end end
module test_wdm_watchdog;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LT = 16;
	localparam int UT = 64;
	localparam int CM = 200;
	logic sys_clk = 0, rst_b = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
	logic osc = 0, osc_run = 1, halt = 0, idle = 0, rc = 0, fv = 0, push = 0, pop = 0, clr = 0;
	logic [7:0] awa = 0, ara = 0, rom = 0;
	logic [15:0] fa = 0;
	logic [31:0] wd = 0, d;
	logic [31:0] bad [3] = '{32'h59, 32'h1D, 32'h18};
	logic [1:0] r;
	wire [1:0] bresp, rresp;
	wire awr, wrdy, bv, arr, rv, pin, oe, oval, trap, ipnd;
	wire [31:0] rdata;
	wire [7:0] opc;
	int fail_count = 0, total_checks = 0, n;
	time t0;
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (osc_run) osc <= ~osc;
	wdm_watchdog #(.LOWER_TC(LT), .UPPER_BASE_TC(UT), .CM_TIMEOUT_CYC(CM)) i_wdm_watchdog (
		.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .osc_input(osc),
		.halt_mode(halt), .idle_mode(idle), .osc_option_rc(rc), .fault_port_pin_i(pin),
		.fault_out_n_o(oval), .fault_out_n_oe(oe), .fetch_valid(fv), .fetch_addr(fa),
		.rom_data(rom), .fetch_opcode(opc), .stack_push(push), .stack_pop(pop),
		.clear_trap_pending_op(clr), .trap_pending(trap), .idle_tick_pending(ipnd));
	wdm_pin_pullup i_wdm_pin_pullup (.sys_clk(sys_clk), .drive_val(oval), .drive_en(oe),
		.pin_level(pin));
	task automatic print_verdict();
		if (fail_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic tmo();
		fail_count++;
		$display("ERROR %0t wait limit reached", $time);
		print_verdict();
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int k;
		k = 0;
		@(posedge sys_clk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			k++;
			if (awv && awr) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
		end
		while (!(bv && brdy) && k < 50);
		if (k >= 50) tmo();
		r = bresp;
		brdy <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		int k;
		k = 0;
		@(posedge sys_clk);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			k++;
			if (arv && arr) arv <= 1'b0;
		end
		while (!(rv && rrdy) && k < 50);
		if (k >= 50) tmo();
		d = rdata;
		r = rresp;
		rrdy <= 1'b0;
	endtask
	// bounded wait for the pin enable; n holds the cycles spent
	task automatic wait_oe(input logic lvl, input int lim);
		n = 0;
		while (oe !== lvl && n < lim)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= lim) tmo();
	endtask
	// service write, then the pin enable a few cycles later
	task automatic sv(input logic [31:0] v, input logic exp_oe);
		wr(`WDM_OFS_SERVICE, v);
		cyc(5);
		`CK(oe, exp_oe)
	endtask
	task automatic win(input logic [31:0] lim);
		rd(`WDM_OFS_WINDOW);
		`CK(d <= lim, 1'b1)
	endtask
	initial
	begin
		cyc(10);
		rst_b <= 1'b1;
		rd(`WDM_OFS_SERVICE);
		`CK(d, 32'h0000_00C1)
		rd(`WDM_OFS_STATUS);
		`CK({d[15:8], d[2:0]}, {8'h6F, 3'b000})
		wr(8'h20, 32'h0);
		`CK(r, 2'h2)
		wr(`WDM_OFS_STATUS, 32'h0);
		`CK(r, 2'h2)
		rd(8'h20);
		`CK({r, d}, {2'h2, 32'h0})
		sv(32'h19, 1'b0);
		rd(`WDM_OFS_SERVICE);
		`CK(d, 32'h0000_0001)
		sv(32'h19, 1'b1);
		t0 = $time;
		wr(`WDM_OFS_SERVICE, 32'h19);
		wait_oe(1'b0, 600);
		n = int'(($time - t0) / 100);
		`CK(n inside {[150:340]}, 1'b1)
		cyc(8);
		win(1);
		cyc(LT * 10 + 20);
		sv(32'h19, 1'b0);
		win(3);
		for (int i = 0; i < 3; i++)
		begin
			cyc(LT * 10 + 20);
			sv(bad[i], 1'b1);
			wait_oe(1'b0, 600);
			rd(`WDM_OFS_SERVICE);
			`CK(d, 32'h0000_0001)
		end
		t0 = $time;
		wait_oe(1'b1, 1000);
		n = int'(($time - t0) / 100);
		`CK(n inside {[(UT - 4) * 10:UT * 10 + 20]}, 1'b1)
		wait_oe(1'b0, 600);
		cyc(300);
		halt <= 1'b1;
		cyc(UT * 10 + 100);
		`CK(oe, 1'b0)
		halt <= 1'b0;
		win(1);
		rc <= 1'b1;
		cyc(300);
		halt <= 1'b1;
		cyc(100);
		halt <= 1'b0;
		win(36);
		`CK(d >= 32'd28, 1'b1)
		wr(`WDM_OFS_CONTROL, 32'h1);
		halt <= 1'b1;
		cyc(20);
		halt <= 1'b0;
		win(1);
		cyc(300);
		idle <= 1'b1;
		cyc(50);
		idle <= 1'b0;
		win(1);
		halt <= 1'b1;
		osc_run <= 1'b0;
		wait_oe(1'b1, CM + 100);
		cyc(800);
		`CK(oe, 1'b1)
		osc_run <= 1'b1;
		halt <= 1'b0;
		t0 = $time;
		wait_oe(1'b0, 600);
		n = int'(($time - t0) / 100);
		`CK(n inside {[150:400]}, 1'b1)
		fv <= 1'b1;
		fa <= 16'h0100;
		rom <= 8'hA5;
		cyc(1);
		fa <= 16'h7FFF;
		cyc(1);
		fv <= 1'b0;
		`CK({opc, trap}, {8'hA5, 1'b0})
		cyc(2);
		`CK({opc, trap}, {8'h00, 1'b1})
		clr <= 1'b1;
		cyc(1);
		clr <= 1'b0;
		cyc(2);
		`CK(trap, 1'b0)
		rst_b <= 1'b0;
		cyc(10);
		rst_b <= 1'b1;
		rd(`WDM_OFS_IDLE_CNT);
		`CK(d != 32'h0, 1'b1)
		push <= 1'b1;
		cyc(1);
		push <= 1'b0;
		pop <= 1'b1;
		cyc(1);
		pop <= 1'b0;
		cyc(2);
		`CK(trap, 1'b0)
		pop <= 1'b1;
		cyc(1);
		pop <= 1'b0;
		cyc(2);
		`CK(trap, 1'b1)
		n = 0;
		while (ipnd !== 1'b1 && n < 45000)
		begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 45000) tmo();
		`CK(ipnd, 1'b1)
		wr(`WDM_OFS_CONTROL, 32'h2);
		cyc(2);
		`CK(ipnd, 1'b0)
		print_verdict();
	end
endmodule // test_wdm_watchdog
bind wdm_watchdog wdm_watchdog_properties i_wdm_watchdog_properties (.sys_clk(sys_clk),
	.rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fault_out_n_o(fault_out_n_o),
	.fault_out_n_oe(fault_out_n_oe), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
	.fetch_opcode(fetch_opcode), .clear_trap_pending_op(clear_trap_pending_op),
	.trap_pending(trap_pending));

// ---- wdm_pin_pullup.sv ----
// Purpose: pull-up and reset-circuit side of the open-drain fault pin
// Assumes: the device pulls the line only while its enable is high
// Notes: the pull-up lifts the line slowly, so release is seen late
module wdm_pin_pullup #(
	parameter int RISE_CYC = 3
) (
	// clock
	input wire logic sys_clk,
	// open-drain driver
	input wire logic drive_val,
	input wire logic drive_en,
	// line level
	output logic pin_level
);
	int rise_cnt = 0;
	always @(posedge sys_clk)
	begin
		if (drive_en)
			rise_cnt <= 0;
		else if (rise_cnt < RISE_CYC)
			rise_cnt <= rise_cnt + 1;
	end
	// no stale level once released: the resistor decides
	assign pin_level = drive_en ? drive_val : (rise_cnt >= RISE_CYC);
endmodule // wdm_pin_pullup

// ---- wdm_watchdog.v ----
// Purpose: windowed watchdog, clock monitor, idle counter and trap detection
// Assumes: halt/idle/fetch/stack strobes come from logic on sys_clk
// Notes: fault pin is open drain; pin level and oscillator input are synchronised
// Function
// - clock monitor passes 10 kHz, rejects 10 Hz
// - reset holds both detectors inactive
// - reset arms max window, monitor enabled
// - first keyed write sets window and monitor
// - later writes compared against stored fields
// - fault pin active low, otherwise released
// - hold low 16-32 cycles after pin low
// - window restarts when fault pin returns high
// - services ignored while fault is active
// - clock error holds pin low until recovery
// - key field reads back as zeros
// - window detector suspended in halt and idle
// - clock monitor keeps running in halt, idle
// - rc without delay resumes window after halt
// - otherwise halt exit restarts the window
// - idle exit performs an automatic service
// - first service accepted anywhere in reset window
// - idle counter unreset, pending flag every 4096
// - unimplemented fetch returns zero opcode, trap
// - stack starts 06F, over-pop traps
// - lower 2048, upper 8k to 64k
// - matching service restarts, mismatch faults
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`include "wdm_watchdog_regs.vh"

module wdm_watchdog #(
	parameter LOWER_TC = `WDM_LOWER_TC,
	parameter UPPER_BASE_TC = `WDM_UPPER_BASE_TC,
	parameter CM_TIMEOUT_CYC = `WDM_CM_TIMEOUT_US * `WDM_CLK_MHZ
) (
	// clock and reset
	input wire sys_clk,
	input wire rst_b,
	// axi4-lite write address and data
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// axi4-lite write response
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// oscillator and power modes
	input wire osc_input,
	input wire halt_mode,
	input wire idle_mode,
	input wire osc_option_rc,
	// fault pin, open drain
	input wire fault_port_pin_i,
	output wire fault_out_n_o,
	output wire fault_out_n_oe,
	// program fetch and stack events, trap and idle flags
	input wire fetch_valid,
	input wire [15:0] fetch_addr,
	input wire [7:0] rom_data,
	output wire [7:0] fetch_opcode,
	input wire stack_push,
	input wire stack_pop,
	input wire clear_trap_pending_op,
	output wire trap_pending,
	output wire idle_tick_pending
);

	localparam ST_IDLE = 2'h0;
	localparam ST_ASSERT = 2'h1;
	localparam ST_HOLD = 2'h2;
	localparam ST_WAITHI = 2'h3;
	localparam [16:0] LOWER_LIM = LOWER_TC[16:0];
	localparam [19:0] UPPER_BASE = UPPER_BASE_TC[19:0];
	localparam [13:0] CM_LIMIT = CM_TIMEOUT_CYC[13:0];
	localparam [3:0] TC_LAST = 4'd`WDM_TC_DIV - 4'h1;
	// release on the tick after the count reaches this, one tick of margin
	localparam [4:0] HOLD_LAST = 5'd`WDM_HOLD_TC;

	// bus registers
	reg awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	reg [1:0] bresp_reg, rresp_reg;
	reg [31:0] rdata_reg;
	reg [7:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg aw_got_reg, w_got_reg;

	// watchdog state
	reg [3:0] tc_div_reg;
	reg tc_tick_reg;
	reg [1:0] wsel_reg;
	reg cm_en_reg;
	reg configured_reg;
	reg halt_clock_delay_sel_reg;
	reg [16:0] win_cnt_reg;
	reg [1:0] fstate_reg;
	reg [4:0] hold_cnt_reg;
	reg fault_drive_reg;
	reg halt_d_reg, idle_d_reg;

	// synchronisers
	reg pin_s1_reg, pin_s2_reg;
	reg osc_s1_reg, osc_s2_reg, osc_s3_reg;

	// clock monitor
	reg [13:0] cm_cnt_reg;
	reg clk_err_reg;

	// idle counter, no reset by design
	reg [15:0] idle_counter_reg = 16'h0000;
	reg idle_pnd_reg;

	// trap detection
	reg [7:0] sp_reg;
	reg trap_pnd_reg;
	reg [7:0] opcode_reg;

	wire wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;
	wire wr_svc = wr_fire && (awaddr_reg == `WDM_OFS_SERVICE) && wstrb_reg[0];
	wire wr_ctl = wr_fire && (awaddr_reg == `WDM_OFS_CONTROL) && wstrb_reg[0];
	wire [7:0] svc_data = wdata_reg[7:0];
	wire key_ok = svc_data[`WDM_SVC_KEY_HI:`WDM_SVC_KEY_LO] == `WDM_SVC_KEY;
	wire fields_ok = key_ok && (svc_data[7:6] == wsel_reg) && (svc_data[0] == cm_en_reg);
	wire fault_busy = fstate_reg != ST_IDLE;
	wire [19:0] upper_full = UPPER_BASE << wsel_reg;
	wire [16:0] upper_last = upper_full[16:0] - 17'h00001;
	wire suspended = halt_mode || idle_mode;
	wire halt_exit = halt_d_reg && !halt_mode;
	wire idle_exit = idle_d_reg && !idle_mode;
	wire svc_taken = wr_svc && !fault_busy;
	wire svc_bad = svc_taken && (configured_reg ? (!fields_ok || win_cnt_reg < LOWER_LIM) : !key_ok);
	wire svc_good = svc_taken && !svc_bad;
	wire timeout = !fault_busy && !suspended && tc_tick_reg && (win_cnt_reg == upper_last);
	wire wd_trigger = svc_bad || timeout;
	wire idle_toggle = tc_tick_reg && (idle_counter_reg[11:0] == 12'hFFF);

	// bus write channel: address and data taken in either order
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= 2'h0;
		end
		else
		begin
			if (awready_reg && s_axi_awvalid)
			begin
				awaddr_reg <= {s_axi_awaddr[7:2], 2'h0};
				aw_got_reg <= 1'b1;
				awready_reg <= 1'b0;
			end
			if (wready_reg && s_axi_wvalid)
			begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				w_got_reg <= 1'b1;
				wready_reg <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				case (awaddr_reg)
					`WDM_OFS_SERVICE, `WDM_OFS_CONTROL: bresp_reg <= 2'h0;
					default: bresp_reg <= 2'h2;
				endcase
			end
			if (bvalid_reg && s_axi_bready)
			begin
				bvalid_reg <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg <= 1'b1;
			end
		end
	end

	// bus read channel, one cycle from address to data
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= 2'h0;
		end
		else if (arready_reg && s_axi_arvalid)
		begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b1;
			rresp_reg <= 2'h0;
			rdata_reg <= 32'h00000000;
			case ({s_axi_araddr[7:2], 2'h0})
				`WDM_OFS_SERVICE: rdata_reg[7:0] <= {wsel_reg, 5'h00, cm_en_reg};
				`WDM_OFS_CONTROL: rdata_reg[`WDM_CTL_HALT_CLOCK_DELAY_SEL_BIT] <= halt_clock_delay_sel_reg;
				`WDM_OFS_STATUS: rdata_reg <= {16'h0000, sp_reg, 3'h0, trap_pnd_reg,
					idle_pnd_reg, configured_reg, clk_err_reg, fault_busy};
				`WDM_OFS_WINDOW: rdata_reg[16:0] <= win_cnt_reg;
				`WDM_OFS_IDLE_CNT: rdata_reg[15:0] <= idle_counter_reg;
				default: rresp_reg <= 2'h2;
			endcase
		end
		else if (rvalid_reg && s_axi_rready)
		begin
			rvalid_reg <= 1'b0;
			arready_reg <= 1'b1;
		end
	end

	// instruction cycle tick, one tenth of sys_clk
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			tc_div_reg <= 4'h0;
			tc_tick_reg <= 1'b0;
		end
		else
		begin
			tc_tick_reg <= (tc_div_reg == TC_LAST);
			tc_div_reg <= (tc_div_reg == TC_LAST) ? 4'h0 : tc_div_reg + 4'h1;
		end
	end

	// synchronisers for the pin level and the oscillator input
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			pin_s1_reg <= 1'b1;
			pin_s2_reg <= 1'b1;
			osc_s1_reg <= 1'b0;
			osc_s2_reg <= 1'b0;
			osc_s3_reg <= 1'b0;
		end
		else
		begin
			pin_s1_reg <= fault_port_pin_i;
			pin_s2_reg <= pin_s1_reg;
			osc_s1_reg <= osc_input;
			osc_s2_reg <= osc_s1_reg;
			osc_s3_reg <= osc_s2_reg;
		end
	end

	// clock monitor: error when no oscillator edge within 1 ms; the gap between
	// 100 us (10 kHz cycle) and 100 ms (10 Hz cycle) gives margin both ways
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			cm_cnt_reg <= 14'h0000;
			clk_err_reg <= 1'b0;
		end
		else if (!cm_en_reg || (osc_s2_reg && !osc_s3_reg))
		begin
			cm_cnt_reg <= 14'h0000;
			clk_err_reg <= 1'b0;
		end
		else if (cm_cnt_reg == CM_LIMIT)
			clk_err_reg <= 1'b1;
		else
			cm_cnt_reg <= cm_cnt_reg + 14'h0001;
	end

	// configuration and window timing
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			wsel_reg <= `WDM_SVC_WSEL_RST;
			cm_en_reg <= `WDM_SVC_CM_RST;
			configured_reg <= 1'b0;
			halt_clock_delay_sel_reg <= 1'b0;
			win_cnt_reg <= 17'h00000;
			halt_d_reg <= 1'b0;
			idle_d_reg <= 1'b0;
		end
		else
		begin
			halt_d_reg <= halt_mode;
			idle_d_reg <= idle_mode;
			if (wr_ctl)
				halt_clock_delay_sel_reg <= wdata_reg[`WDM_CTL_HALT_CLOCK_DELAY_SEL_BIT];
			if (svc_good && !configured_reg)
			begin
				wsel_reg <= svc_data[7:6];
				cm_en_reg <= svc_data[0];
				configured_reg <= 1'b1;
			end
			if (fault_busy)
			begin
				if (fstate_reg == ST_WAITHI && pin_s2_reg)
					win_cnt_reg <= 17'h00000;
			end
			else if (svc_good)
				win_cnt_reg <= 17'h00000;
			else if (idle_exit)
				win_cnt_reg <= 17'h00000;
			else if (halt_exit && !(osc_option_rc && !halt_clock_delay_sel_reg))
				win_cnt_reg <= 17'h00000;
			else if (tc_tick_reg && !suspended && !timeout)
				win_cnt_reg <= win_cnt_reg + 17'h00001;
		end
	end

	// fault pin sequencer; a clock error and a watchdog trigger share it
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			fstate_reg <= ST_IDLE;
			hold_cnt_reg <= 5'h00;
			fault_drive_reg <= 1'b0;
		end
		else
		begin
			case (fstate_reg)
				ST_IDLE:
				begin
					if (wd_trigger || clk_err_reg)
					begin
						fstate_reg <= ST_ASSERT;
						fault_drive_reg <= 1'b1;
					end
				end
				ST_ASSERT:
				begin
					hold_cnt_reg <= 5'h00;
					if (!pin_s2_reg)
						fstate_reg <= ST_HOLD;
				end
				ST_HOLD:
				begin
					// one spare tick covers sync delay and tick phase, so 16-32 tc holds
					if (clk_err_reg)
						hold_cnt_reg <= 5'h00;
					else if (tc_tick_reg && hold_cnt_reg == HOLD_LAST)
					begin
						fstate_reg <= ST_WAITHI;
						fault_drive_reg <= 1'b0;
					end
					else if (tc_tick_reg)
						hold_cnt_reg <= hold_cnt_reg + 5'h01;
				end
				ST_WAITHI:
				begin
					if (clk_err_reg)
					begin
						fstate_reg <= ST_ASSERT;
						fault_drive_reg <= 1'b1;
					end
					else if (pin_s2_reg)
						fstate_reg <= ST_IDLE;
				end
				default:
				begin
					fstate_reg <= ST_IDLE;
					fault_drive_reg <= 1'b0;
				end
			endcase
		end
	end

	// idle counter keeps its count through reset, only the flag is cleared
	always @(posedge sys_clk)
	begin
		if (tc_tick_reg)
			idle_counter_reg <= idle_counter_reg + 16'h0001;
	end

	always @(posedge sys_clk)
	begin
		if (!rst_b)
			idle_pnd_reg <= 1'b0;
		else if (idle_toggle)
			idle_pnd_reg <= 1'b1;
		else if (wr_ctl && wdata_reg[`WDM_CTL_CLR_IDLE_BIT])
			idle_pnd_reg <= 1'b0;
	end

	// illegal-condition detection
	always @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			sp_reg <= `WDM_SP_RST;
			trap_pnd_reg <= 1'b0;
			opcode_reg <= 8'h00;
		end
		else
		begin
			if (stack_push && !stack_pop)
				sp_reg <= sp_reg - 8'h02;
			else if (stack_pop && !stack_push)
				sp_reg <= sp_reg + 8'h02;
			if (fetch_valid)
				opcode_reg <= (fetch_addr > `WDM_ROM_TOP) ? 8'h00 : rom_data;
			// over-pop reads all ones from 070 upward, so the return lands on 7FFF
			if ((fetch_valid && fetch_addr > `WDM_ROM_TOP) ||
				(stack_pop && sp_reg >= `WDM_SP_LAST && `WDM_POP_RETURN > `WDM_ROM_TOP))
				trap_pnd_reg <= 1'b1;
			else if (clear_trap_pending_op || (wr_ctl && wdata_reg[`WDM_CTL_CLR_TRAP_BIT]))
				trap_pnd_reg <= 1'b0;
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign fault_out_n_o = 1'b0;
	assign fault_out_n_oe = fault_drive_reg;
	assign fetch_opcode = opcode_reg;
	assign trap_pending = trap_pnd_reg;
	assign idle_tick_pending = idle_pnd_reg;

endmodule // wdm_watchdog

// ---- wdm_watchdog_properties.sv ----
// Purpose: bus, fault pin and trap properties of the watchdog
// Assumes: one clock, rst_b synchronous and active low
// Notes: hold figure is 16 instruction cycles of 10 sys_clk each
module wdm_watchdog_properties (
	// clock and reset
	input wire sys_clk,
	input wire rst_b,
	// axi4-lite handshakes
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// fault pin
	input wire fault_out_n_o,
	input wire fault_out_n_oe,
	// fetch and trap
	input wire fetch_valid,
	input wire [15:0] fetch_addr,
	input wire [7:0] fetch_opcode,
	input wire clear_trap_pending_op,
	input wire trap_pending
);
	logic [15:0] oe_cnt;
	always @(posedge sys_clk)
	begin
		if (!rst_b || !fault_out_n_oe)
			oe_cnt <= 16'h0000;
		else if (oe_cnt != 16'hFFFF)
			oe_cnt <= oe_cnt + 16'h0001;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	AST_RST_QUIET: assert property ($rose(rst_b) |-> !fault_out_n_oe && !trap_pending)
		else $error("fault or trap active after reset");
	AST_PIN_LOW: assert property (fault_out_n_oe |-> fault_out_n_o == 1'b0)
		else $error("fault pin driven high");
	AST_HOLD_MIN: assert property ($fell(fault_out_n_oe) |-> oe_cnt >= 16'd160)
		else $error("fault pin released too early");
	AST_WR_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped");
	AST_FETCH_TRAP: assert property (fetch_valid && fetch_addr > 16'h0FFF |=>
		fetch_opcode == 8'h00 ##[0:2] trap_pending)
		else $error("undefined fetch not trapped");
	AST_TRAP_STICKY: assert property (trap_pending && !clear_trap_pending_op
		&& s_axi_awready |=> trap_pending)
		else $error("trap flag lost");
endmodule // wdm_watchdog_properties

// ---- wdm_watchdog_regs.vh ----
// Purpose: constants for the windowed watchdog and clock monitor
// Assumes: 10 MHz sys_clk, instruction cycle is one tenth of it
// Notes: AXI4-Lite byte offsets, service register fields, timing counts
`ifndef WDM_WATCHDOG_REGS_VH
`define WDM_WATCHDOG_REGS_VH

// register byte offsets
`define WDM_OFS_SERVICE 8'h00
`define WDM_OFS_CONTROL 8'h04
`define WDM_OFS_STATUS 8'h08
`define WDM_OFS_WINDOW 8'h0C
`define WDM_OFS_IDLE_CNT 8'h10

// service register fields
`define WDM_SVC_WSEL_HI 7
`define WDM_SVC_WSEL_LO 6
`define WDM_SVC_KEY_HI 5
`define WDM_SVC_KEY_LO 1
`define WDM_SVC_CM_BIT 0
`define WDM_SVC_KEY 5'h0C
`define WDM_SVC_WSEL_RST 2'h3
`define WDM_SVC_CM_RST 1'h1

// control register bits
`define WDM_CTL_HALT_CLOCK_DELAY_SEL_BIT 0
`define WDM_CTL_CLR_IDLE_BIT 1
`define WDM_CTL_CLR_TRAP_BIT 2

// status register bits
`define WDM_STS_FAULT_BIT 0
`define WDM_STS_CLKERR_BIT 1
`define WDM_STS_CONFIG_BIT 2
`define WDM_STS_IDLE_PND_BIT 3
`define WDM_STS_TRAP_PND_BIT 4
`define WDM_STS_SP_LO 8

// timing
`define WDM_CLK_MHZ 10
`define WDM_TC_DIV 10
`define WDM_LOWER_TC 2048
`define WDM_UPPER_BASE_TC 8192
`define WDM_HOLD_TC 16
`define WDM_CM_TIMEOUT_US 1000
`define WDM_IDLE_TICK_TC 4096

// illegal-condition detection
`define WDM_SP_RST 8'h6F
`define WDM_SP_LAST 8'h6F
`define WDM_POP_RETURN 16'h7FFF
`define WDM_ROM_TOP 16'h0FFF

`endif
